// >>> common/ldp_pkg.sv
// Parameter numbers, field positions, command codes and carrier types of the driver map
package ldp_pkg;

  // Parameter numbers
  localparam logic [15:0] P_FREQ_SET = 16'h0100;
  localparam logic [15:0] P_FREQ_MIN = 16'h0101;
  localparam logic [15:0] P_FREQ_MAX = 16'h0102;
  localparam logic [15:0] P_DUR_SET = 16'h0200;
  localparam logic [15:0] P_DUR_MIN = 16'h0201;
  localparam logic [15:0] P_DUR_MAX = 16'h0202;
  localparam logic [15:0] P_CUR_SET = 16'h0300;
  localparam logic [15:0] P_CUR_MIN = 16'h0301;
  localparam logic [15:0] P_CUR_MAX = 16'h0302;
  localparam logic [15:0] P_CUR_MEAS = 16'h0307;
  localparam logic [15:0] P_CUR_CAL = 16'h030e;
  localparam logic [15:0] P_VOLT_MEAS = 16'h0407;
  localparam logic [15:0] P_DEV_STATE = 16'h0700;
  localparam logic [15:0] P_SERIAL = 16'h0701;
  localparam logic [15:0] P_MODEL = 16'h0702;
  localparam logic [15:0] P_FEATURES = 16'h0703;
  localparam logic [15:0] P_LOCK = 16'h0800;
  localparam logic [15:0] P_TEC_SET = 16'h0a10;
  localparam logic [15:0] P_TEC_HI = 16'h0a11;
  localparam logic [15:0] P_TEC_LO = 16'h0a12;
  localparam logic [15:0] P_TEC_ABS_MAX = 16'h0a13;
  localparam logic [15:0] P_TEC_ABS_MIN = 16'h0a14;
  localparam logic [15:0] P_TEC_MEAS = 16'h0a15;
  localparam logic [15:0] P_TEC_CUR_MEAS = 16'h0a16;
  localparam logic [15:0] P_TEC_CUR_LIM = 16'h0a17;
  localparam logic [15:0] P_TEC_VOLT_MEAS = 16'h0a18;
  localparam logic [15:0] P_TEC_VOLT_LIM = 16'h0a19;
  localparam logic [15:0] P_TEC_STATE = 16'h0a1a;
  localparam logic [15:0] P_TEC_CUR_ABS = 16'h0a1c;
  localparam logic [15:0] P_TEC_VOLT_ABS = 16'h0a1d;
  localparam logic [15:0] P_TEC_COEF = 16'h0a1e;
  localparam logic [15:0] P_TEC_BETA = 16'h0a1f;

  // Calibration default and range
  localparam logic [15:0] CAL_RESET = 16'h2710;
  localparam logic [15:0] CAL_LOW = 16'h251c;
  localparam logic [15:0] CAL_HIGH = 16'h2904;

  // State command codes
  localparam logic [15:0] CMD_START = 16'h0008;
  localparam logic [15:0] CMD_STOP = 16'h0010;
  localparam logic [15:0] CMD_CUR_INT = 16'h0020;
  localparam logic [15:0] CMD_CUR_EXT = 16'h0040;
  localparam logic [15:0] CMD_EN_EXT = 16'h0200;
  localparam logic [15:0] CMD_EN_INT = 16'h0400;
  localparam logic [15:0] CMD_ILK_ALLOW = 16'h1000;
  localparam logic [15:0] CMD_ILK_DENY = 16'h2000;
  localparam logic [15:0] CMD_NTC_DENY = 16'h4000;
  localparam logic [15:0] CMD_NTC_ALLOW = 16'h8000;

  // Status mask bit positions
  localparam int ST_POWER = 0;
  localparam int ST_RUN = 1;
  localparam int ST_CUR_INT = 2;
  localparam int ST_EN_INT = 4;
  localparam int ST_NTC_DENY = 6;
  localparam int ST_ILK_DENY = 7;
  localparam int LK_ILK = 1;
  localparam int LK_OVC = 3;
  localparam int LK_HEAT = 4;
  localparam int LK_NTC = 5;

  // Characters of the text protocol
  localparam logic [7:0] CH_SET = 8'h50;
  localparam logic [7:0] CH_GET = 8'h4a;
  localparam logic [7:0] CH_ANS = 8'h4b;
  localparam logic [7:0] CH_ERR = 8'h45;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [3:0] REPLY_GET_LEN = 4'hb;
  localparam logic [3:0] REPLY_ERR_LEN = 4'h6;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_NUM = 3'b001,
    S_SPACE = 3'b010,
    S_VAL = 3'b011,
    S_END = 3'b100,
    S_SKIP = 3'b101,
    S_SEND = 3'b110
  } ldp_state_type;

  typedef struct packed {
    logic [15:0] cur_meas;
    logic [15:0] volt_meas;
    logic [15:0] tec_temp_meas;
    logic [15:0] tec_cur_meas;
    logic [15:0] tec_volt_meas;
  } ldp_meas_type;

  typedef struct packed {
    logic [15:0] freq;
    logic [15:0] dur;
    logic [15:0] cur;
    logic [15:0] cal;
    logic [15:0] tec_temp;
    logic [15:0] tec_hi;
    logic [15:0] tec_lo;
    logic [15:0] tec_ilim;
    logic [15:0] tec_vlim;
    logic [15:0] tec_coef;
    logic [15:0] beta;
  } ldp_setpt_type;

  typedef struct packed {
    logic ilk;
    logic ovc;
    logic heat;
    logic ntc;
  } ldp_fault_type;

endpackage : ldp_pkg

// >>> dv/ldp_host_model.sv
// Host model: sends command text and takes reply characters
`timescale 1ns/1ps
`default_nettype none
module ldp_host_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic stall,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic tx_ready,
  output logic got,
  output logic [7:0] got_data
);
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
  end
  // Offers one byte, held until taken
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    rx_data <= b;
    rx_valid <= 1'b1;
    @(negedge clk);
    while (!rx_ready && n < 300) begin
      n++;
      @(negedge clk);
    end
    @(posedge clk);
  endtask : put
  // Released line shows inverted last byte
  task automatic idle();
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
  endtask : idle
  // Reply consumer, stalls at random
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_ready <= 1'b0;
      got <= 1'b0;
      got_data <= 8'h00;
    end else begin
      tx_ready <= !stall;
      got <= tx_valid && tx_ready;
      got_data <= tx_data;
    end
  end
endmodule : ldp_host_model
`default_nettype wire

// >>> dv/ldp_param_map_tb_top.sv
// Self-checking bench of the driver parameter map
`timescale 1ns/1ps
`default_nettype none
module ldp_param_map_tb_top import ldp_pkg::*; ;
  localparam logic [15:0] SN = 16'h5a3c; // Arbitrary
  localparam logic [15:0] MID = 16'h0c71; // Arbitrary
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] rx_data, tx_data, got_data;
  logic rx_valid, rx_ready, tx_valid, tx_ready, got;
  logic laser_run, current_internal, enable_internal, interlock_deny, ntc_interlock_deny;
  logic tec_run, tec_interlock_deny;
  logic [4:0] drv_st;
  ldp_meas_type meas = '0;
  ldp_fault_type fault_pin = '0;
  ldp_setpt_type setpt;
  logic [15:0] lfsr = 16'h0044;
  logic [7:0] exq[$];
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [15:0] cd[11] = '{16'h0400, 16'h0020, 16'h2000, 16'h4000, 16'h0008, 16'h0010,
    16'h0200, 16'h0040, 16'h1000, 16'h8000, 16'h0008};
  logic [4:0] ev[11] = '{5'h04, 5'h0c, 5'h0e, 5'h0f, 5'h1f, 5'h0f, 5'h0b, 5'h03, 5'h01,
    5'h00, 5'h00};
  logic [15:0] tc[4] = '{16'h0008, 16'h2000, 16'h0010, 16'h1000};
  logic [1:0] te[4] = '{2'h2, 2'h3, 2'h1, 2'h0};
  logic [15:0] cv[6] = '{16'h2800, 16'hffff, 16'h0000, 16'h2904, 16'h251c, 16'h2903};

  initial forever #5 clk = ~clk;

  assign drv_st = {laser_run, current_internal, enable_internal, interlock_deny,
    ntc_interlock_deny};

  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt

  always @(posedge clk) lfsr <= nxt(lfsr);

  ldp_param_map #(.SERIAL_NUMBER(SN), .MODEL_ID(MID), .FEATURE_MASK(16'h000e)) i_ldp_param_map (
    .clk(clk), .rstn(rstn), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .meas(meas),
    .fault_pin(fault_pin), .setpt(setpt), .laser_run(laser_run),
    .current_internal(current_internal), .enable_internal(enable_internal),
    .interlock_deny(interlock_deny), .ntc_interlock_deny(ntc_interlock_deny),
    .tec_run(tec_run), .tec_interlock_deny(tec_interlock_deny));

  ldp_host_model i_ldp_host_model (.clk(clk), .rstn(rstn), .stall(lfsr[3]),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .rx_data(rx_data),
    .rx_valid(rx_valid), .tx_ready(tx_ready), .got(got), .got_data(got_data));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  always @(negedge clk) begin
    if (got === 1'b1) check(got_data, exq.size() ? exq.pop_front() : 'x);
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end

  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction : hx

  function automatic string hex4(input logic [15:0] v);
    return $sformatf("%c%c%c%c", hx(v[15:12]), hx(v[11:8]), hx(v[7:4]), hx(v[3:0]));
  endfunction : hex4

  task automatic expect_s(input string s);
    foreach (s[i]) exq.push_back(s[i]);
  endtask : expect_s

  task automatic tx(input string s);
    int n;
    foreach (s[i]) i_ldp_host_model.put(s[i]);
    i_ldp_host_model.idle();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((tx_valid || exq.size() != 0) && n < 400);
    @(posedge clk);
  endtask : tx

  task automatic get(input logic [15:0] n, input logic [15:0] v);
    expect_s({"K", hex4(n), " ", hex4(v), "\r"});
    tx($sformatf("J%04h\r", n));
  endtask : get

  task automatic set(input logic [15:0] n, input logic [15:0] v);
    tx($sformatf("P%04h %04h\r", n, v));
  endtask : set

  initial begin
    logic [15:0] v, e;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    meas <= {lfsr, ~lfsr, lfsr, lfsr, lfsr};
    @(posedge clk);
    get(P_DEV_STATE, 16'h0001);
    check(drv_st, 5'h00);
    get(P_CUR_CAL, CAL_RESET);
    for (int i = 0; i < 7; i++) begin
      v = (i < 6) ? cv[i] : lfsr;
      e = (v < CAL_LOW) ? CAL_LOW : (v > CAL_HIGH) ? CAL_HIGH : v;
      set(P_CUR_CAL, v);
      check(setpt.cal, e);
    end
    get(P_CUR_CAL, e);
    set(P_SERIAL, 16'h1234);
    get(P_SERIAL, SN);
    set(P_CUR_MEAS, 16'h0bb8);
    get(P_CUR_MEAS, meas.cur_meas);
    get(P_MODEL, MID);
    get(P_FEATURES, 16'h000e);
    for (int i = 0; i < 11; i++) begin
      set(P_DEV_STATE, cd[i]);
      check(drv_st, ev[i]);
      if (i == 4) get(P_DEV_STATE, 16'h00d7);
      if (i == 5) get(P_DEV_STATE, 16'h00d5);
    end
    for (int i = 0; i < 4; i++) begin
      set(P_TEC_STATE, tc[i]);
      check({tec_run, tec_interlock_deny}, te[i]);
      if (i == 1) get(P_TEC_STATE, 16'h0043);
    end
    get(P_TEC_STATE, 16'h0001);
    v = lfsr;
    set(P_TEC_BETA, v);
    check(setpt.beta, v);
    get(P_TEC_BETA, v);
    fault_pin <= 4'hf;
    repeat (5) @(posedge clk);
    get(P_LOCK, 16'h003a);
    fault_pin <= 4'ha;
    repeat (5) @(posedge clk);
    get(P_LOCK, 16'h0012);
    expect_s({"E", "0001\r"});
    tx("X12\r");
    expect_s({"E", "0000\r"});
    tx("J07g0\r");
    expect_s({"E", "0000\r"});
    tx("J07\r");
    expect_s("K0000 0000\r");
    tx("J1234\r");
    check(16'(exq.size()), 16'h0000);
    print_verdict();
  end
endmodule : ldp_param_map_tb_top
`default_nettype wire

// >>> rtl/ldp_param_map.sv
// Text command interpreter and parameter map of the laser driver
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// (R1) Calibration parameter 030E is read/write, in hundredths of a percent.
// (R2) Calibration resets to 2710h; writes are held within 251Ch to 2904h.
// (R3) Parameter 0307 reads back measured laser current, tenths of ampere.
// (R4) Writes to 0700 are command codes for run, current, enable, interlocks.
// (R5) Device state read always shows bit 0 set for powered.
// (R6) State bits 1,2,4,6,7 show run, internal current, internal enable, denials.
// (R7) Parameter 0701 returns serial number and ignores writes.
// (R8) Parameter 0702 returns model and version identifier, read only.
// (R9) Parameter 0703 is capability mask: frequency, duration, current bits.
// (R10) Parameter 0800 shows interlock, over-current, overheat, NTC faults.
// (R11) TEC state read: bit 0 one, bit 1 running, bit 6 interlock denied.
// (R12) Writes to 0A1A start, stop, allow or deny the TEC interlock.
// (R13) After reset: external current set, external enable, interlock allowed.
// (R14) Host starts exchanges; set command P nnnn vvvv CR gets no reply.
// (R15) Get command J nnnn CR is answered K nnnn space vvvv CR; an unknown nnnn is answered K 0000 space 0000 instead.
// (R16) Bad format gives error reply 0000; unknown command gives 0001.
// (R17) Read-only parameters ignore writes; command registers read as status.
module ldp_param_map import ldp_pkg::*; #(
  parameter logic [15:0] FREQ_MIN = 16'h0000,
  parameter logic [15:0] FREQ_MAX = 16'hffff,
  parameter logic [15:0] DUR_MIN = 16'h0000,
  parameter logic [15:0] DUR_MAX = 16'hffff,
  parameter logic [15:0] CUR_MIN = 16'h0000,
  parameter logic [15:0] CUR_MAX = 16'hffff,
  parameter logic [15:0] TEC_ABS_MIN = 16'h0000,
  parameter logic [15:0] TEC_ABS_MAX = 16'hffff,
  parameter logic [15:0] TEC_CUR_ABS = 16'hffff,
  parameter logic [15:0] TEC_VOLT_ABS = 16'hffff,
  // Arbitrary identity values
  parameter logic [15:0] SERIAL_NUMBER = 16'h0001,
  parameter logic [15:0] MODEL_ID = 16'h0001,
  parameter logic [15:0] FEATURE_MASK = 16'h000f
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire ldp_meas_type meas,
  input wire ldp_fault_type fault_pin,
  output ldp_setpt_type setpt,
  output logic laser_run,
  output logic current_internal,
  output logic enable_internal,
  output logic interlock_deny,
  output logic ntc_interlock_deny,
  output logic tec_run,
  output logic tec_interlock_deny
);

  if (FREQ_MIN > FREQ_MAX || DUR_MIN > DUR_MAX || CUR_MIN > CUR_MAX) begin : g_bad_limits
    $error("Minimum above maximum");
  end

  function automatic logic [4:0] hex_nib(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) begin
      hex_nib = {1'b1, 4'(c - 8'h30)};
    end else if (c >= 8'h41 && c <= 8'h46) begin
      hex_nib = {1'b1, 4'(c - 8'h37)};
    end else if (c >= 8'h61 && c <= 8'h66) begin
      hex_nib = {1'b1, 4'(c - 8'h57)};
    end else begin
      hex_nib = 5'h00;
    end
  endfunction : hex_nib

  function automatic logic [7:0] nib_hex(input logic [3:0] n);
    nib_hex = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : nib_hex

  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp16

  ldp_state_type state_r;
  logic [1:0] digit_cnt_r;
  logic is_set_r, err_unknown_r;
  logic [15:0] num_r, val_r;
  logic [7:0] reply_r [0:10];
  logic [3:0] reply_len_r, reply_idx_r;
  logic [3:0] fault_ff1_r, fault_ff2_r, fault_ff3_r, fault_r;
  logic run_r, cur_int_r, en_int_r, ilk_deny_r, ntc_deny_r, tec_run_r, tec_ilk_deny_r;
  ldp_setpt_type setpt_r;
  logic [15:0] dev_status, tec_status, lock_status, read_val;
  logic [4:0] nib;
  logic read_known, rx_take, exec_set, exec_get, bad_format, bad_command, err_done;

  assign rx_ready = (state_r != S_SEND);
  assign rx_take = rx_valid && rx_ready;
  assign nib = hex_nib(rx_data);
  assign exec_set = rx_take && state_r == S_END && rx_data == CH_CR && is_set_r; // [R14]
  assign exec_get = rx_take && state_r == S_END && rx_data == CH_CR && !is_set_r; // [R15]
  assign err_done = rx_take && state_r == S_SKIP && rx_data == CH_CR; // [R16]
  assign bad_command = rx_take && state_r == S_IDLE && rx_data != CH_SET &&
                       rx_data != CH_GET && rx_data != CH_CR;
  always_comb begin
    bad_format = 1'b0;
    if (rx_take) begin
      case (state_r)
        S_NUM, S_VAL: bad_format = !nib[4];
        S_SPACE: bad_format = rx_data != CH_SPACE;
        S_END: bad_format = rx_data != CH_CR;
        default: bad_format = 1'b0;
      endcase
    end
  end

  // Command parser
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= S_IDLE;
      digit_cnt_r <= 2'h0;
      is_set_r <= 1'b0;
      num_r <= 16'h0000;
      val_r <= 16'h0000;
      err_unknown_r <= 1'b0;
    end else if (bad_format) begin
      err_unknown_r <= 1'b0; // [R16]
      state_r <= (rx_data == CH_CR) ? S_SEND : S_SKIP;
    end else if (rx_take || state_r == S_SEND) begin
      case (state_r)
        S_IDLE: begin
          digit_cnt_r <= 2'h0;
          is_set_r <= rx_data == CH_SET;
          if (rx_data == CH_SET || rx_data == CH_GET) begin
            state_r <= S_NUM;
          end else if (bad_command) begin
            err_unknown_r <= 1'b1; // [R16]
            state_r <= S_SKIP;
          end
        end
        S_NUM: begin
          num_r <= {num_r[11:0], nib[3:0]};
          digit_cnt_r <= digit_cnt_r + 2'h1;
          if (digit_cnt_r == 2'h3) begin
            state_r <= is_set_r ? S_SPACE : S_END;
          end
        end
        S_SPACE: begin
          digit_cnt_r <= 2'h0;
          state_r <= S_VAL;
        end
        S_VAL: begin
          val_r <= {val_r[11:0], nib[3:0]};
          digit_cnt_r <= digit_cnt_r + 2'h1;
          if (digit_cnt_r == 2'h3) begin
            state_r <= S_END;
          end
        end
        S_END: state_r <= exec_set ? S_IDLE : S_SEND; // [R14] [R15]
        S_SKIP: begin
          if (err_done) begin
            state_r <= S_SEND;
          end
        end
        S_SEND: begin
          if (tx_ready && reply_idx_r == reply_len_r - 4'h1) begin
            state_r <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Read-back masks
  always_comb begin
    dev_status = 16'h0000;
    dev_status[ST_POWER] = 1'b1; // [R5]
    dev_status[ST_RUN] = run_r; // [R6]
    dev_status[ST_CUR_INT] = cur_int_r;
    dev_status[ST_EN_INT] = en_int_r;
    dev_status[ST_NTC_DENY] = ntc_deny_r;
    dev_status[ST_ILK_DENY] = ilk_deny_r;
    tec_status = 16'h0000;
    tec_status[ST_POWER] = 1'b1; // [R11]
    tec_status[ST_RUN] = tec_run_r;
    tec_status[ST_NTC_DENY] = tec_ilk_deny_r;
    lock_status = 16'h0000;
    lock_status[LK_ILK] = fault_r[3]; // [R10]
    lock_status[LK_OVC] = fault_r[2];
    lock_status[LK_HEAT] = fault_r[1];
    lock_status[LK_NTC] = fault_r[0];
  end

  // Parameter read decode
  always_comb begin
    read_known = 1'b1;
    case (num_r)
      P_FREQ_SET: read_val = setpt_r.freq;
      P_FREQ_MIN: read_val = FREQ_MIN;
      P_FREQ_MAX: read_val = FREQ_MAX;
      P_DUR_SET: read_val = setpt_r.dur;
      P_DUR_MIN: read_val = DUR_MIN;
      P_DUR_MAX: read_val = DUR_MAX;
      P_CUR_SET: read_val = setpt_r.cur;
      P_CUR_MIN: read_val = CUR_MIN;
      P_CUR_MAX: read_val = CUR_MAX;
      P_CUR_MEAS: read_val = meas.cur_meas; // [R3]
      P_CUR_CAL: read_val = setpt_r.cal; // [R1]
      P_VOLT_MEAS: read_val = meas.volt_meas;
      P_DEV_STATE: read_val = dev_status; // [R17]
      P_SERIAL: read_val = SERIAL_NUMBER; // [R7]
      P_MODEL: read_val = MODEL_ID; // [R8]
      P_FEATURES: read_val = FEATURE_MASK; // [R9]
      P_LOCK: read_val = lock_status; // [R10]
      P_TEC_SET: read_val = setpt_r.tec_temp;
      P_TEC_HI: read_val = setpt_r.tec_hi;
      P_TEC_LO: read_val = setpt_r.tec_lo;
      P_TEC_ABS_MAX: read_val = TEC_ABS_MAX;
      P_TEC_ABS_MIN: read_val = TEC_ABS_MIN;
      P_TEC_MEAS: read_val = meas.tec_temp_meas;
      P_TEC_CUR_MEAS: read_val = meas.tec_cur_meas;
      P_TEC_CUR_LIM: read_val = setpt_r.tec_ilim;
      P_TEC_VOLT_MEAS: read_val = meas.tec_volt_meas;
      P_TEC_VOLT_LIM: read_val = setpt_r.tec_vlim;
      P_TEC_STATE: read_val = tec_status; // [R11]
      P_TEC_CUR_ABS: read_val = TEC_CUR_ABS;
      P_TEC_VOLT_ABS: read_val = TEC_VOLT_ABS;
      P_TEC_COEF: read_val = setpt_r.tec_coef;
      P_TEC_BETA: read_val = setpt_r.beta;
      default: begin
        read_val = 16'h0000;
        read_known = 1'b0;
      end
    endcase
  end

  // Reply builder and sender
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 11; i++) begin
        reply_r[i] <= 8'h00;
      end
      reply_len_r <= 4'h0;
      reply_idx_r <= 4'h0;
    end else if (exec_get) begin
      reply_r[0] <= CH_ANS; // [R15]
      for (int i = 0; i < 4; i++) begin
        reply_r[1 + i] <= read_known ? nib_hex(num_r[15 - 4 * i -: 4]) : CH_ZERO;
        reply_r[6 + i] <= nib_hex(read_val[15 - 4 * i -: 4]);
      end
      reply_r[5] <= CH_SPACE;
      reply_r[10] <= CH_CR;
      reply_len_r <= REPLY_GET_LEN;
      reply_idx_r <= 4'h0;
    end else if (err_done || (bad_format && rx_data == CH_CR)) begin
      reply_r[0] <= CH_ERR; // [R16]
      reply_r[1] <= CH_ZERO;
      reply_r[2] <= CH_ZERO;
      reply_r[3] <= CH_ZERO;
      reply_r[4] <= err_unknown_r && state_r == S_SKIP ? 8'h31 : CH_ZERO;
      reply_r[5] <= CH_CR;
      reply_len_r <= REPLY_ERR_LEN;
      reply_idx_r <= 4'h0;
    end else if (state_r == S_SEND && tx_ready) begin
      reply_idx_r <= (reply_idx_r == reply_len_r - 4'h1) ? 4'h0 : reply_idx_r + 4'h1;
    end
  end

  assign tx_valid = (state_r == S_SEND);
  assign tx_data = reply_r[reply_idx_r];

  // Fault pin synchroniser, change taken when stages two and three agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fault_ff1_r <= 4'h0;
      fault_ff2_r <= 4'h0;
      fault_ff3_r <= 4'h0;
      fault_r <= 4'h0;
    end else begin
      fault_ff1_r <= fault_pin;
      fault_ff2_r <= fault_ff1_r;
      fault_ff3_r <= fault_ff2_r;
      for (int i = 0; i < 4; i++) begin
        if (fault_ff2_r[i] == fault_ff3_r[i]) begin
          fault_r[i] <= fault_ff3_r[i];
        end
      end
    end
  end

  // Driver state commands
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_r <= 1'b0;
      cur_int_r <= 1'b0; // [R13]
      en_int_r <= 1'b0;
      ilk_deny_r <= 1'b0;
      ntc_deny_r <= 1'b0;
    end else if (exec_set && num_r == P_DEV_STATE) begin
      run_r <= (val_r == CMD_START) && en_int_r; // [R4]
      case (val_r)
        CMD_CUR_INT: cur_int_r <= 1'b1;
        CMD_CUR_EXT: cur_int_r <= 1'b0;
        CMD_EN_EXT: en_int_r <= 1'b0;
        CMD_EN_INT: en_int_r <= 1'b1;
        CMD_ILK_ALLOW: ilk_deny_r <= 1'b0;
        CMD_ILK_DENY: ilk_deny_r <= 1'b1;
        CMD_NTC_DENY: ntc_deny_r <= 1'b1;
        CMD_NTC_ALLOW: ntc_deny_r <= 1'b0;
        default: ;
      endcase
    end
  end

  // Cooler state commands
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tec_run_r <= 1'b0;
      tec_ilk_deny_r <= 1'b0;
    end else if (exec_set && num_r == P_TEC_STATE) begin
      case (val_r)
        CMD_START: tec_run_r <= 1'b1; // [R12]
        CMD_STOP: tec_run_r <= 1'b0;
        CMD_ILK_ALLOW: tec_ilk_deny_r <= 1'b0;
        CMD_ILK_DENY: tec_ilk_deny_r <= 1'b1;
        default: ;
      endcase
    end
  end

  // Writable setpoints; read-only numbers fall to the default and store nothing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      setpt_r <= '0;
      setpt_r.freq <= FREQ_MIN;
      setpt_r.dur <= DUR_MIN;
      setpt_r.cur <= CUR_MIN;
      setpt_r.cal <= CAL_RESET; // [R2]
    end else if (exec_set) begin
      case (num_r)
        P_FREQ_SET: setpt_r.freq <= clamp16(val_r, FREQ_MIN, FREQ_MAX);
        P_DUR_SET: setpt_r.dur <= clamp16(val_r, DUR_MIN, DUR_MAX);
        P_CUR_SET: setpt_r.cur <= clamp16(val_r, CUR_MIN, CUR_MAX);
        P_CUR_CAL: setpt_r.cal <= clamp16(val_r, CAL_LOW, CAL_HIGH); // [R1] [R2]
        P_TEC_SET: setpt_r.tec_temp <= val_r;
        P_TEC_HI: setpt_r.tec_hi <= val_r;
        P_TEC_LO: setpt_r.tec_lo <= val_r;
        P_TEC_CUR_LIM: setpt_r.tec_ilim <= val_r;
        P_TEC_VOLT_LIM: setpt_r.tec_vlim <= val_r;
        P_TEC_COEF: setpt_r.tec_coef <= val_r;
        P_TEC_BETA: setpt_r.beta <= val_r;
        default: ; // [R17]
      endcase
    end
  end

  assign setpt = setpt_r;
  assign laser_run = run_r;
  assign current_internal = cur_int_r;
  assign enable_internal = en_int_r;
  assign interlock_deny = ilk_deny_r;
  assign ntc_interlock_deny = ntc_deny_r;
  assign tec_run = tec_run_r;
  assign tec_interlock_deny = tec_ilk_deny_r;

  a_cal_range: assert property (@(posedge clk) disable iff (!rstn) // [R2]
    setpt_r.cal >= CAL_LOW && setpt_r.cal <= CAL_HIGH) else $error("Calibration out of range");
  a_start_cmd: assert property (@(posedge clk) disable iff (!rstn) // [R4]
    exec_set && num_r == P_DEV_STATE && val_r == CMD_START && en_int_r |=> run_r)
    else $error("Start command ignored");
  a_other_stops: assert property (@(posedge clk) disable iff (!rstn) // [R4]
    exec_set && num_r == P_DEV_STATE && val_r != CMD_START |=> !run_r)
    else $error("State command left output running");
  a_state_mask: assert property (@(posedge clk) disable iff (!rstn) // [R5] [R6]
    dev_status[0] && dev_status[1] == laser_run && dev_status[7] == interlock_deny &&
    dev_status[2] == current_internal) else $error("Device state mask wrong");
  a_tec_cmds: assert property (@(posedge clk) disable iff (!rstn) // [R12]
    exec_set && num_r == P_TEC_STATE && val_r == CMD_ILK_DENY |=> tec_interlock_deny)
    else $error("Cooler interlock deny ignored");
  a_tec_mask: assert property (@(posedge clk) disable iff (!rstn) // [R11]
    tec_status[0] && tec_status[1] == tec_run && tec_status[6] == tec_interlock_deny)
    else $error("Cooler state mask wrong");
  a_set_silent: assert property (@(posedge clk) disable iff (!rstn) // [R14]
    exec_set |=> !tx_valid[*2]) else $error("Reply sent to set command");
  a_get_reply: assert property (@(posedge clk) disable iff (!rstn) // [R15]
    exec_get |=> tx_valid && tx_data == CH_ANS ##0 (tx_valid [*8]) ##1 (tx_valid [*3]))
    else $error("Get reply malformed");
  a_err_reply: assert property (@(posedge clk) disable iff (!rstn) // [R16]
    err_done |=> tx_valid && tx_data == CH_ERR) else $error("Error reply missing");
  a_ro_kept: assert property (@(posedge clk) disable iff (!rstn) // [R17]
    exec_set && num_r == P_CUR_MEAS |=> $stable(setpt_r)) else $error("Read-only write stored");

endmodule : ldp_param_map

`default_nettype wire
